/* verilog/adl_consts.svh */
// register offsets, reset values, field positions and counts of the level register bank
`ifndef ADL_CONSTS_SVH
`define ADL_CONSTS_SVH

`define ADL_OFS_GATE_REL_B1   8'h1e
`define ADL_OFS_GATE_REL_B2   8'h1f
`define ADL_OFS_GATE_REL_B3   8'h20
`define ADL_OFS_GATE_REL_B4   8'h21
`define ADL_OFS_LIM_REL_TOP   8'h22
`define ADL_OFS_LIM_REL_MID   8'h23
`define ADL_OFS_LIM_REL_LOW   8'h24
`define ADL_OFS_ENERGY_TOP    8'h26
`define ADL_OFS_ENERGY_LOW    8'h27
`define ADL_OFS_WIDE_BAND     8'h28
`define ADL_OFS_MONO_UPPER    8'h29
`define ADL_OFS_MONO_LOWER    8'h2a

`define ADL_RST_GATE_REL_B1   8'h00
`define ADL_RST_GATE_REL_B2   8'h00
`define ADL_RST_GATE_REL_B3   8'h53
`define ADL_RST_GATE_REL_B4   8'h00
`define ADL_RST_LIM_REL_TOP   8'h08
`define ADL_RST_LIM_REL_MID   8'h00
`define ADL_RST_LIM_REL_LOW   8'h00
`define ADL_RST_ENERGY_TOP    8'h00
`define ADL_RST_ENERGY_LOW    8'h10
`define ADL_RST_WIDE_BAND     8'h00
`define ADL_RST_MONO_UPPER    8'h00
`define ADL_RST_MONO_LOWER    8'h00
`define ADL_RST_UNMAPPED      8'h00

`define ADL_MONO_KEY_UPPER    8'h30
`define ADL_MONO_KEY_LOWER    8'h06

`define ADL_WB_SECOND_FIR     3
`define ADL_WB_OUT_COMP       2
`define ADL_WB_ALIAS          1
`define ADL_WB_WRITE_MASK     8'h0e

`define ADL_GATE_COUNT        2048
`define ADL_LIM_STEP          24'h000100
`define ADL_DEV_ADDR          7'h30

`endif

/* verilog/adl_pkg.sv */
// types shared by the level register bank
package adl_pkg;

    typedef enum logic [3:0] {
        ADL_IDLE,
        ADL_ADDR,
        ADL_ACK,
        ADL_REG,
        ADL_WDATA,
        ADL_RDATA,
        ADL_RACK
    } adl_i2c_st_e;

    typedef struct packed {
        logic [7:0] gate_release_byte1;
        logic [7:0] gate_release_byte2;
        logic [7:0] gate_release_byte3;
        logic [7:0] gate_release_byte4;
        logic [7:0] release_thresh_top;
        logic [7:0] release_thresh_mid;
        logic [7:0] release_thresh_low;
        logic [7:0] energy_coef_upper;
        logic [7:0] energy_coef_lower;
        logic [7:0] wide_band;
        logic [7:0] mono_unlock_upper;
        logic [7:0] mono_unlock_lower;
    } adl_regs_s;

    typedef struct packed {
        adl_i2c_st_e st;
        logic        scl_p;
        logic        sda_p;
        logic [3:0]  cnt;
        logic [7:0]  sh;
        logic [7:0]  tx;
        logic [7:0]  ptr;
        logic        rw;
        logic        have_ptr;
        logic        rack_ok;
        logic        sda_oe;
        adl_regs_s   regs;
        logic        mono;
        logic [15:0] gate_cnt;
        logic        gate_act;
        logic [23:0] lim_level;
        logic        lim_eng;
    } adl_state_s;

endpackage

/* verilog/adl_sync.sv */
// two-flop synchroniser for one pin level
`timescale 1ns/1ps
module adl_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic mclk_i,
    input  wire logic arst_n_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_q;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_q <= RST_VAL;
            q_o    <= RST_VAL;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule

/* verilog/adl_level_regs.sv */
// level register bank behind the serial control port, with gate and limiter trackers
//
// Overview of operation
// - gate release level is four bytes; third byte resets to 0x53, others zero.
// - gate levels are 1.31 magnitudes; full scale code is 2147483647.
// - limiter caps at attack level, then walks the cap toward release threshold.
// - limiter release threshold is 21 bits from bytes 0x22, 0x23, 0x24.
// - limiter thresholds are 3.21 power codes; full power is 2097152.
// - energy coefficient is 16 bits, upper byte 0x26, lower byte 0x27.
// - coefficient expands to 1.23: zero, upper[6:0], lower, eight zeros.
// - energy coefficient resets to 1/2048: upper zero, lower 0x10.
// - wide band bits 3, 2, 1 enable second fir, output comp, alias filters.
// - mono only when mono enable set, upper key 0x30, lower key 0x06.
// - any unmet mono condition, including zero upper key, keeps stereo.
// - an active gate drops once any sample exceeds the release level.
// - gate starts after 2048 consecutive both-channel samples below attack level.
`timescale 1ns/1ps
`include "adl_consts.svh"
module adl_level_regs
    import adl_pkg::*;
#(
    parameter logic [6:0]  DEV_ADDR   = `ADL_DEV_ADDR,
    parameter int          GATE_COUNT = `ADL_GATE_COUNT,
    parameter logic [23:0] LIM_STEP   = `ADL_LIM_STEP
) (
    input  wire logic        mclk_i,
    input  wire logic        arst_n_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    input  wire logic        mono_en_i,
    input  wire logic        gate_en_i,
    input  wire logic        sample_valid_i,
    input  wire logic [31:0] left_mag_i,
    input  wire logic [31:0] right_mag_i,
    input  wire logic [31:0] gate_attack_level_i,
    input  wire logic        power_valid_i,
    input  wire logic [23:0] power_i,
    input  wire logic [23:0] lim_attack_i,
    output logic [31:0]      gate_release_level_o,
    output logic [20:0]      lim_release_o,
    output logic [23:0]      energy_coef_o,
    output logic             second_fir_enable_o,
    output logic             output_filter_comp_enable_o,
    output logic             alias_filter_enable_o,
    output logic             mono_mode_o,
    output logic             gate_active_o,
    output logic [23:0]      lim_cap_o,
    output logic             lim_engaged_o
);

    // refuse values the counters cannot serve
    if (GATE_COUNT < 1 || GATE_COUNT > 65535) begin
        $error("GATE_COUNT must lie in 1..65535");
    end

    if (LIM_STEP == 24'h000000) begin
        $error("LIM_STEP must not be zero");
    end

    // quiet-run limit at the counter's width
    localparam logic [15:0] GATE_CNT_W = 16'(GATE_COUNT);

    adl_state_s s_q;
    adl_state_s s_d;
    logic       scl_s;
    logic       sda_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    logic [7:0] rd_byte;
    logic [7:0] rd_next;
    logic [23:0] lim_rel24;

    adl_sync #(.RST_VAL(1'b1)) u_sync_scl (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .d_i      (scl_i),
        .q_o      (scl_s)
    );

    adl_sync #(.RST_VAL(1'b1)) u_sync_sda (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .d_i      (sda_i),
        .q_o      (sda_s)
    );

    // register read mux; unmapped offsets read zero
    function automatic logic [7:0] reg_read(input adl_regs_s r, input logic [7:0] a);
        logic [7:0] v;
        v = `ADL_RST_UNMAPPED;
        case (a)
            `ADL_OFS_GATE_REL_B1: v = r.gate_release_byte1;
            `ADL_OFS_GATE_REL_B2: v = r.gate_release_byte2;
            `ADL_OFS_GATE_REL_B3: v = r.gate_release_byte3;
            `ADL_OFS_GATE_REL_B4: v = r.gate_release_byte4;
            `ADL_OFS_LIM_REL_TOP: v = r.release_thresh_top;
            `ADL_OFS_LIM_REL_MID: v = r.release_thresh_mid;
            `ADL_OFS_LIM_REL_LOW: v = r.release_thresh_low;
            `ADL_OFS_ENERGY_TOP:  v = r.energy_coef_upper;
            `ADL_OFS_ENERGY_LOW:  v = r.energy_coef_lower;
            `ADL_OFS_WIDE_BAND:   v = r.wide_band & `ADL_WB_WRITE_MASK;
            `ADL_OFS_MONO_UPPER:  v = r.mono_unlock_upper;
            `ADL_OFS_MONO_LOWER:  v = r.mono_unlock_lower;
            default:              v = `ADL_RST_UNMAPPED;
        endcase
        return v;
    endfunction

    // register write; unmapped offsets are dropped
    function automatic adl_regs_s reg_write(input adl_regs_s r, input logic [7:0] a,
                                            input logic [7:0] d);
        adl_regs_s n;
        n = r;
        case (a)
            `ADL_OFS_GATE_REL_B1: n.gate_release_byte1 = d;
            `ADL_OFS_GATE_REL_B2: n.gate_release_byte2 = d;
            `ADL_OFS_GATE_REL_B3: n.gate_release_byte3 = d;
            `ADL_OFS_GATE_REL_B4: n.gate_release_byte4 = d;
            `ADL_OFS_LIM_REL_TOP: n.release_thresh_top = d;
            `ADL_OFS_LIM_REL_MID: n.release_thresh_mid = d;
            `ADL_OFS_LIM_REL_LOW: n.release_thresh_low = d;
            `ADL_OFS_ENERGY_TOP:  n.energy_coef_upper  = d;
            `ADL_OFS_ENERGY_LOW:  n.energy_coef_lower  = d;
            `ADL_OFS_WIDE_BAND:   n.wide_band = d & `ADL_WB_WRITE_MASK;
            `ADL_OFS_MONO_UPPER:  n.mono_unlock_upper  = d;
            `ADL_OFS_MONO_LOWER:  n.mono_unlock_lower  = d;
            default:              n = r;
        endcase
        return n;
    endfunction

    assign scl_rise  = scl_s & ~s_q.scl_p;
    assign scl_fall  = ~scl_s & s_q.scl_p;
    assign bus_start = scl_s & s_q.scl_p & s_q.sda_p & ~sda_s;
    assign bus_stop  = scl_s & s_q.scl_p & ~s_q.sda_p & sda_s;
    assign rd_byte   = reg_read(s_q.regs, s_q.ptr);
    assign rd_next   = s_q.tx << 1;

    // 21-bit release code sits in the low bits of the three bytes
    assign lim_rel24 = {3'b000, s_q.regs.release_thresh_top[4:0],
                        s_q.regs.release_thresh_mid, s_q.regs.release_thresh_low};

    always_comb begin
        s_d       = s_q;
        s_d.scl_p = scl_s;
        s_d.sda_p = sda_s;

        // serial control port: 7-bit address, pointer byte, auto-incrementing data
        if (bus_start) begin
            s_d.st       = ADL_ADDR;
            s_d.cnt      = 4'h0;
            s_d.sda_oe   = 1'b0;
            s_d.have_ptr = 1'b0;
        end else if (bus_stop) begin
            s_d.st     = ADL_IDLE;
            s_d.sda_oe = 1'b0;
        end else begin
            case (s_q.st)
                ADL_IDLE: begin
                    s_d.sda_oe = 1'b0;
                end

                // byte in on rising clocks; the fall after bit 8 acks
                ADL_ADDR, ADL_REG, ADL_WDATA: begin
                    if (scl_rise && s_q.cnt != 4'h8) begin
                        s_d.sh  = {s_q.sh[6:0], sda_s};
                        s_d.cnt = s_q.cnt + 4'h1;
                    end else if (scl_fall && s_q.cnt == 4'h8) begin
                        s_d.cnt    = 4'h0;
                        s_d.sda_oe = 1'b1;
                        s_d.st     = ADL_ACK;
                        if (s_q.st == ADL_ADDR) begin
                            s_d.rw = s_q.sh[0];
                            // foreign address: no ack, wait for a start
                            if (s_q.sh[7:1] != DEV_ADDR) begin
                                s_d.sda_oe = 1'b0;
                                s_d.st     = ADL_IDLE;
                            end
                        end else if (s_q.st == ADL_REG) begin
                            s_d.ptr      = s_q.sh;
                            s_d.have_ptr = 1'b1;
                        end else begin
                            // byte lands, pointer moves on
                            s_d.regs = reg_write(s_q.regs, s_q.ptr, s_q.sh);
                            s_d.ptr  = s_q.ptr + 8'h01;
                        end
                    end
                end

                ADL_ACK: begin
                    if (scl_fall) begin
                        s_d.sda_oe = 1'b0;
                        if (s_q.rw) begin
                            s_d.tx     = rd_byte;
                            s_d.ptr    = s_q.ptr + 8'h01;
                            s_d.sda_oe = ~rd_byte[7];
                            s_d.st     = ADL_RDATA;
                        end else begin
                            s_d.st = s_q.have_ptr ? ADL_WDATA : ADL_REG;
                        end
                    end
                end

                // one bit per falling clock, then the host's ack
                ADL_RDATA: begin
                    if (scl_fall) begin
                        if (s_q.cnt == 4'h7) begin
                            s_d.cnt    = 4'h0;
                            s_d.sda_oe = 1'b0;
                            s_d.st     = ADL_RACK;
                        end else begin
                            s_d.cnt    = s_q.cnt + 4'h1;
                            s_d.tx     = rd_next;
                            s_d.sda_oe = ~rd_next[7];
                        end
                    end
                end

                // host ack loads the next byte, a nack ends the read
                ADL_RACK: begin
                    if (scl_rise) begin
                        s_d.rack_ok = ~sda_s;
                    end else if (scl_fall) begin
                        if (s_q.rack_ok) begin
                            s_d.tx     = rd_byte;
                            s_d.ptr    = s_q.ptr + 8'h01;
                            s_d.sda_oe = ~rd_byte[7];
                            s_d.st     = ADL_RDATA;
                        end else begin
                            s_d.st = ADL_IDLE;
                        end
                    end
                end

                default: begin
                    s_d.st     = ADL_IDLE;
                    s_d.sda_oe = 1'b0;
                end
            endcase
        end

        // mono needs the enable and both key bytes; anything else stays stereo
        s_d.mono = mono_en_i
                   && s_q.regs.mono_unlock_upper == `ADL_MONO_KEY_UPPER
                   && s_q.regs.mono_unlock_lower == `ADL_MONO_KEY_LOWER;

        // noise gate tracker on 1.31 magnitudes
        if (!gate_en_i) begin
            s_d.gate_cnt = 16'h0000;
            s_d.gate_act = 1'b0;
        end else if (sample_valid_i) begin
            // one loud sample on either channel releases
            if (s_q.gate_act) begin
                if (left_mag_i > gate_release_level_o
                    || right_mag_i > gate_release_level_o) begin
                    s_d.gate_act = 1'b0;
                    s_d.gate_cnt = 16'h0000;
                end
            end else if (left_mag_i < gate_attack_level_i
                         && right_mag_i < gate_attack_level_i) begin
                s_d.gate_cnt = s_q.gate_cnt + 16'h0001;
                if (s_q.gate_cnt + 16'h0001 >= GATE_CNT_W) begin
                    s_d.gate_act = 1'b1;
                    s_d.gate_cnt = 16'h0000;
                end
            end else begin
                s_d.gate_cnt = 16'h0000;
            end
        end

        // limiter cap on 3.21 power codes
        if (power_valid_i) begin
            if (power_i >= lim_attack_i) begin
                s_d.lim_level = lim_attack_i;
                s_d.lim_eng   = 1'b1;
            end else if (s_q.lim_eng) begin
                // step toward release, clamped so it never overshoots
                if (s_q.lim_level > lim_rel24) begin
                    s_d.lim_level = (s_q.lim_level - lim_rel24 > LIM_STEP)
                                    ? s_q.lim_level - LIM_STEP : lim_rel24;
                end else if (s_q.lim_level < lim_rel24) begin
                    s_d.lim_level = (lim_rel24 - s_q.lim_level > LIM_STEP)
                                    ? s_q.lim_level + LIM_STEP : lim_rel24;
                end else begin
                    // release code reached: let go
                    s_d.lim_eng = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q                         <= '0;
            s_q.st                      <= ADL_IDLE;
            // edge memories start at idle bus level: no false edge
            s_q.scl_p                   <= 1'b1;
            s_q.sda_p                   <= 1'b1;

            s_q.regs.gate_release_byte1 <= `ADL_RST_GATE_REL_B1;
            s_q.regs.gate_release_byte2 <= `ADL_RST_GATE_REL_B2;
            s_q.regs.gate_release_byte3 <= `ADL_RST_GATE_REL_B3;
            s_q.regs.gate_release_byte4 <= `ADL_RST_GATE_REL_B4;
            s_q.regs.release_thresh_top <= `ADL_RST_LIM_REL_TOP;
            s_q.regs.release_thresh_mid <= `ADL_RST_LIM_REL_MID;
            s_q.regs.release_thresh_low <= `ADL_RST_LIM_REL_LOW;
            s_q.regs.energy_coef_upper  <= `ADL_RST_ENERGY_TOP;
            s_q.regs.energy_coef_lower  <= `ADL_RST_ENERGY_LOW;
            s_q.regs.wide_band          <= `ADL_RST_WIDE_BAND;
            s_q.regs.mono_unlock_upper  <= `ADL_RST_MONO_UPPER;
            s_q.regs.mono_unlock_lower  <= `ADL_RST_MONO_LOWER;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs are flop bits, regrouped; sda_o and the zero pad bits of energy_coef_o are tied low
    assign sda_o                = 1'b0;
    assign sda_oe_o             = s_q.sda_oe;
    assign gate_release_level_o = {s_q.regs.gate_release_byte1, s_q.regs.gate_release_byte2,
                                   s_q.regs.gate_release_byte3,
                                   s_q.regs.gate_release_byte4};
    assign lim_release_o        = lim_rel24[20:0];
    assign energy_coef_o        = {1'b0, s_q.regs.energy_coef_upper[6:0],
                                   s_q.regs.energy_coef_lower, 8'h00};

    assign second_fir_enable_o         = s_q.regs.wide_band[`ADL_WB_SECOND_FIR];
    assign output_filter_comp_enable_o = s_q.regs.wide_band[`ADL_WB_OUT_COMP];
    assign alias_filter_enable_o       = s_q.regs.wide_band[`ADL_WB_ALIAS];

    assign mono_mode_o          = s_q.mono;
    assign gate_active_o        = s_q.gate_act;
    assign lim_cap_o            = s_q.lim_level;
    assign lim_engaged_o        = s_q.lim_eng;

endmodule

/* bench/adl_level_regs_monitor.sv */
// assertion checker for the level register bank ports
`timescale 1ns/1ps
module adl_level_regs_monitor (
    input wire logic        mclk_i,
    input wire logic        arst_n_i,
    input wire logic        mono_en_i,
    input wire logic        gate_en_i,
    input wire logic        sample_valid_i,
    input wire logic [31:0] left_mag_i,
    input wire logic [31:0] right_mag_i,
    input wire logic [31:0] gate_attack_level_i,
    input wire logic        power_valid_i,
    input wire logic [23:0] power_i,
    input wire logic [23:0] lim_attack_i,
    input wire logic [31:0] gate_release_level_o,
    input wire logic [20:0] lim_release_o,
    input wire logic [23:0] energy_coef_o,
    input wire logic        mono_mode_o,
    input wire logic        gate_active_o,
    input wire logic [23:0] lim_cap_o,
    input wire logic        lim_engaged_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    property p_mono_on;
        mono_mode_o |-> $past(mono_en_i);
    endproperty
    a_mono_on: assert property (p_mono_on) else $error("mono without enable");
    property p_mono_off;
        !mono_en_i |=> !mono_mode_o;
    endproperty
    a_mono_off: assert property (p_mono_off) else $error("mono kept");
    property p_gate_rise;
        $rose(gate_active_o) |-> $past(sample_valid_i && gate_en_i &&
            left_mag_i < gate_attack_level_i && right_mag_i < gate_attack_level_i);
    endproperty
    a_gate_rise: assert property (p_gate_rise) else $error("gate rose without cause");
    property p_gate_drop;
        gate_active_o && gate_en_i && sample_valid_i && (left_mag_i > gate_release_level_o
            || right_mag_i > gate_release_level_o) |=> !gate_active_o;
    endproperty
    a_gate_drop: assert property (p_gate_drop) else $error("gate not released");
    property p_gate_off;
        !gate_en_i |=> !gate_active_o;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("gate active while off");
    property p_lim_att;
        power_valid_i && power_i >= lim_attack_i |=>
            lim_engaged_o && lim_cap_o == $past(lim_attack_i);
    endproperty
    a_lim_att: assert property (p_lim_att) else $error("cap not at attack");
    property p_lim_walk;
        lim_engaged_o && power_valid_i && power_i < lim_attack_i &&
            lim_cap_o > {3'h0, lim_release_o} |=> lim_cap_o < $past(lim_cap_o) &&
            lim_cap_o >= {3'h0, $past(lim_release_o)};
    endproperty
    a_lim_walk: assert property (p_lim_walk) else $error("cap walk wrong");
    property p_energy_fmt;
        energy_coef_o[23] == 1'b0 && energy_coef_o[7:0] == 8'h00;
    endproperty
    a_energy_fmt: assert property (p_energy_fmt) else $error("coef format");
endmodule

/* bench/adl_i2c_host.sv */
// two-wire host model that drives the bank's serial control port
`timescale 1ns/1ps
module adl_i2c_host (
    input  wire logic mclk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_pull_o
);
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end
    // one phase of the serial clock, five master cycles
    task automatic hp();
        repeat (5) @(negedge mclk_i);
    endtask
    // start, or repeated start when the clock is low
    task automatic start_cond();
        sda_pull_o = 1'b0;
        hp();
        scl_o = 1'b1;
        hp();
        sda_pull_o = 1'b1;
        hp();
        scl_o = 1'b0;
        hp();
    endtask
    task automatic stop_cond();
        sda_pull_o = 1'b1;
        hp();
        scl_o = 1'b1;
        hp();
        sda_pull_o = 1'b0;
        hp();
    endtask
    // eight bits msb first, then the acknowledge bit
    task automatic xfer(input logic [7:0] wb, input logic mack,
                        output logic [7:0] rb, output logic sack);
        for (int i = 7; i >= 0; i--) begin
            sda_pull_o = ~wb[i];
            hp();
            scl_o = 1'b1;
            hp();
            rb[i] = sda_i;
            scl_o = 1'b0;
            hp();
        end
        sda_pull_o = mack;
        hp();
        scl_o = 1'b1;
        hp();
        sack = ~sda_i;
        scl_o = 1'b0;
        hp();
    endtask
endmodule

/* bench/tb_adl_level_regs.sv */
// self-checking bench for the level register bank
`timescale 1ns/1ps
`include "adl_consts.svh"
module tb_adl_level_regs;
    localparam int         GC  = 4;
    localparam logic [6:0] DEV = `ADL_DEV_ADDR;
    logic        mclk, arst_n, pull, sda_o, sda_oe, mono_en, gate_en, sv, pv, ack;
    logic        sfir, ocomp, alias_en, mono, gact, leng;
    logic [31:0] lm, rm, gal, grl;
    logic [23:0] pw, la, ecoef, lcap;
    logic [20:0] lrel;
    logic [7:0]  r8;
    logic [7:0]  q[$];
    wire         scl, sda;
    int          miscompares, num_checks;
    assign sda = (sda_oe ? sda_o : 1'b1) & ~pull;
    always #2 mclk = ~mclk;
    adl_i2c_host adl_i2c_host_inst (.mclk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
    adl_level_regs #(.GATE_COUNT(GC)) adl_level_regs_inst (
        .mclk_i(mclk), .arst_n_i(arst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .mono_en_i(mono_en), .gate_en_i(gate_en), .sample_valid_i(sv),
        .left_mag_i(lm), .right_mag_i(rm), .gate_attack_level_i(gal), .power_valid_i(pv),
        .power_i(pw), .lim_attack_i(la), .gate_release_level_o(grl), .lim_release_o(lrel),
        .energy_coef_o(ecoef), .second_fir_enable_o(sfir),
        .output_filter_comp_enable_o(ocomp), .alias_filter_enable_o(alias_en),
        .mono_mode_o(mono), .gate_active_o(gact), .lim_cap_o(lcap), .lim_engaged_o(leng));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic addr_ptr(input logic [7:0] ptr);
        adl_i2c_host_inst.start_cond();
        adl_i2c_host_inst.xfer({DEV, 1'b0}, 1'b0, r8, ack);
        chk(ack, 1, "addr ack");
        adl_i2c_host_inst.xfer(ptr, 1'b0, r8, ack);
        chk(ack, 1, "ptr ack");
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$]);
        addr_ptr(ptr);
        foreach (d[i]) begin
            adl_i2c_host_inst.xfer(d[i], 1'b0, r8, ack);
            chk(ack, 1, "data ack");
        end
        adl_i2c_host_inst.stop_cond();
    endtask
    task automatic rd(input logic [7:0] ptr, input int n);
        q = {};
        addr_ptr(ptr);
        adl_i2c_host_inst.start_cond();
        adl_i2c_host_inst.xfer({DEV, 1'b1}, 1'b0, r8, ack);
        for (int i = 0; i < n; i++) begin
            adl_i2c_host_inst.xfer(8'hff, i < n - 1, r8, ack);
            q.push_back(r8);
        end
        adl_i2c_host_inst.stop_cond();
    endtask
    task automatic pstep(input logic [23:0] p);
        pw = p;
        pv = 1'b1;
        @(negedge mclk);
        pv = 1'b0;
        @(negedge mclk);
    endtask
    task automatic smp(input logic [31:0] l, input logic [31:0] r);
        lm = l;
        rm = r;
        sv = 1'b1;
        @(negedge mclk);
        sv = 1'b0;
        @(negedge mclk);
    endtask
    task automatic below(input int n);
        repeat (n) smp(32'h100, 32'h100);
    endtask
    initial begin
        repeat (100000) @(posedge mclk);
        miscompares++;
        report_and_stop();
    end
    initial begin
        logic [7:0] rst_v[13] = '{0, 0, 8'h53, 0, 8'h08, 0, 0, 0, 0, 8'h10, 0, 0, 0};
        logic [7:0] new_v[11] = '{8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'hff, 8'h12, 8'h34, 0,
                                  8'hff, 8'hff, 8'h0e};
        logic [7:0] wb_v[4] = '{8'h08, 8'h04, 8'h02, 8'h0a};
        {mclk, arst_n, mono_en, gate_en, sv, pv, lm, rm, gal, pw, la} = '0;
        repeat (5) @(negedge mclk);
        arst_n = 1'b1;
        repeat (3) @(negedge mclk);
        chk(grl, 32'h00005300, "gate release reset");
        chk(lrel, 32'h080000, "limiter release reset");
        chk(ecoef, 32'h001000, "energy reset");
        rd(8'h1e, 13);
        foreach (q[i]) chk(q[i], rst_v[i], "reset read");
        la = 24'h080200;
        for (int k = 0; k < 4; k++) begin
            pstep(k == 0 ? 24'h090000 : 24'h000000);
            chk(leng, k < 3, "limiter engaged");
            if (k < 3) chk(lcap, 24'h080200 - 24'(k) * 24'h000100, "cap");
        end
        gate_en = 1'b1;
        gal = 32'h00001a00;
        below(GC - 1);
        smp(32'h1a00, 0);
        below(GC - 1);
        chk(gact, 0, "gate early");
        below(1);
        chk(gact, 1, "gate on");
        smp(0, 32'h5300);
        chk(gact, 1, "gate at level");
        smp(32'h5301, 0);
        chk(gact, 0, "gate released");
        below(GC);
        gate_en = 1'b0;
        @(negedge mclk);
        chk(gact, 0, "gate disabled");
        wr(8'h1e, '{8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'hff, 8'h12, 8'h34, 8'h5a, 8'hff, 8'hff,
                    8'hff});
        chk(grl, 32'ha1b2c3d4, "gate release");
        chk(lrel, 32'h1f1234, "limiter release");
        chk(ecoef, 32'h7fff00, "energy unity");
        rd(8'h1e, 11);
        foreach (q[i]) chk(q[i], new_v[i], "readback");
        foreach (wb_v[i]) begin
            wr(8'h28, '{wb_v[i]});
            chk({sfir, ocomp, alias_en}, wb_v[i][3:1], "filters");
        end
        mono_en = 1'b1;
        @(negedge mclk);
        chk(mono, 0, "mono zero keys");
        wr(8'h29, '{8'h30});
        chk(mono, 0, "mono half key");
        wr(8'h2a, '{8'h06});
        chk(mono, 1, "mono on");
        mono_en = 1'b0;
        @(negedge mclk);
        chk(mono, 0, "mono enable off");
        mono_en = 1'b1;
        wr(8'h29, '{8'h31});
        chk(mono, 0, "mono wrong key");
        adl_i2c_host_inst.start_cond();
        adl_i2c_host_inst.xfer({DEV ^ 7'h01, 1'b0}, 1'b0, r8, ack);
        chk(ack, 0, "foreign address");
        adl_i2c_host_inst.stop_cond();
        report_and_stop();
    end
endmodule
bind adl_level_regs adl_level_regs_monitor adl_level_regs_monitor_inst (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .mono_en_i(mono_en_i), .gate_en_i(gate_en_i),
    .sample_valid_i(sample_valid_i), .left_mag_i(left_mag_i), .right_mag_i(right_mag_i),
    .gate_attack_level_i(gate_attack_level_i), .power_valid_i(power_valid_i),
    .power_i(power_i), .lim_attack_i(lim_attack_i), .lim_release_o(lim_release_o),
    .gate_release_level_o(gate_release_level_o), .energy_coef_o(energy_coef_o),
    .mono_mode_o(mono_mode_o), .gate_active_o(gate_active_o), .lim_cap_o(lim_cap_o),
    .lim_engaged_o(lim_engaged_o));
